// File: ppm_pkg.sv
// package: power management and eeprom loader constants
package ppm_pkg;
  localparam logic [7:0] OFS_CAP = 8'h40;
  localparam logic [7:0] OFS_CSR = 8'h44;
  localparam logic [7:0] OFS_USER = 8'h48;
  localparam logic [7:0] OFS_VENDOR = 8'h00;
  localparam logic [7:0] OFS_CLASS = 8'h08;
  localparam logic [7:0] OFS_SUBSYS = 8'h2C;
  localparam logic [7:0] CAP_ID = 8'h01;
  localparam logic [7:0] CAP_NEXT = 8'h00;
  localparam logic [2:0] CAP_VERSION = 3'h2;
  localparam logic CAP_CLOCK = 1'b1;
  localparam logic [4:0] CAP_WAKE_SUPPORT = 5'h08;
  localparam int CSR_WAKE_STATUS_BIT = 15;
  localparam int CSR_WAKE_EN_BIT = 8;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3HOT = 2'h3;
  // default identity values, arbitrary
  localparam logic [15:0] DEF_VENDOR = 16'h1234;
  localparam logic [15:0] DEF_DEVICE = 16'h5678;
  localparam logic [7:0] DEF_REVISION = 8'h01;
  localparam logic [23:0] DEF_CLASS = 24'h070002;
  localparam logic [31:0] USER_RESET = 32'h00000000;
  localparam int EE_WORDS = 8;
  localparam int EE_ADDR_BITS = 6;
  localparam logic [1:0] EE_READ_OP = 2'h2;
  localparam int EE_CLK_DIV = 4;
  localparam int LOAD_LIMIT = 65536;
endpackage

// File: ppm_eeprom_reader.sv
// serial eeprom word reader, three-wire read command
`timescale 1ns/1ps
`default_nettype none
module ppm_eeprom_reader #(
  parameter int ADDR_BITS = 6,
  parameter int CLK_DIV = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic [ADDR_BITS-1:0] wordAddr,
  output logic busy,
  output logic done,
  output logic [15:0] wordData,
  // eeprom pins
  output logic eeSelect,
  output logic eeClock,
  output logic eeDataIn,
  input wire logic eeDataOut
);
  // frame: start bit, 2 op bits, address, 16 data bits
  localparam int FRAME = 3 + ADDR_BITS + 16;
  localparam logic [5:0] FRAME_LAST = 6'(FRAME - 1);
  localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);
  logic [7:0] divQ;
  logic [5:0] bitQ;
  logic [FRAME-1:0] cmdQ;
  logic [15:0] shiftQ;
  logic phaseQ;
  wire tick = busy && (divQ == DIV_LAST);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      divQ <= 8'h00;
      bitQ <= 6'h00;
      phaseQ <= 1'b0;
      cmdQ <= '0;
      shiftQ <= 16'h0000;
      wordData <= 16'h0000;
      eeSelect <= 1'b0;
      eeClock <= 1'b0;
      eeDataIn <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          eeSelect <= 1'b1;
          divQ <= 8'h00;
          bitQ <= 6'h00;
          phaseQ <= 1'b0;
          cmdQ <= {1'b1, ppm_pkg::EE_READ_OP, wordAddr, 16'h0000};
        end
      end else begin
        divQ <= tick ? 8'h00 : divQ + 8'h01;
        if (tick) begin
          phaseQ <= ~phaseQ;
          if (!phaseQ) begin
            eeDataIn <= cmdQ[FRAME-1];
            cmdQ <= {cmdQ[FRAME-2:0], 1'b0};
            eeClock <= 1'b0;
          end else begin
            eeClock <= 1'b1;
            // data bits sampled msb first on rising clock
            if (bitQ > 6'(2 + ADDR_BITS)) begin
              shiftQ <= {shiftQ[14:0], eeDataOut};
            end
            if (bitQ == FRAME_LAST) begin
              busy <= 1'b0;
              done <= 1'b1;
              eeSelect <= 1'b0;
              eeClock <= 1'b0;
              wordData <= {shiftQ[14:0], eeDataOut};
            end
            bitQ <= bitQ + 6'h01;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: ppm_power_mgmt.sv
// power management capability, user word and eeprom config load
// Overview of operation
// - capability words placed at offset 0x40
// - id 01, next 00, version 010
// - wake supported from D3hot only
// - clock needed for wake, bit 19
// - data and bridge bytes read zero
// - wake enable and power state writable
// - wake status sticky, write one clears
// - only D0, D3hot, D3cold; wake D3hot
// - D0 entry from reset starts uninitialized substate
// - active D0 answers all, interrupts allowed
// - D3hot: config only, no memory, interrupts
// - receive and flow control run in D3hot
// - wake on start bit or modem delta
// - D3hot to D0 keeps all registers
// - drivers disabled during D3hot to D0
// - reset restores all power-on defaults
// - user word at 0x48, eeprom only
// - eeprom read as 16-bit words
// - load only if select pin high
// - load ends within 65536 clocks
// - eight words map to config fields
// - first class word uses upper byte
`timescale 1ns/1ps
`default_nettype none
module ppm_power_mgmt #(
  parameter int LOAD_LIMIT = ppm_pkg::LOAD_LIMIT,
  parameter int CHANNELS = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration access
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [31:0] cfgWdata,
  input wire logic [3:0] cfgByteEn,
  output logic [31:0] cfgRdata,
  output logic cfgRvalid,
  // software marks end of initialization
  input wire logic swInitDone,
  // channel wake sources
  input wire logic [CHANNELS-1:0] rxLine,
  input wire logic [CHANNELS*4-1:0] modemDelta,
  // gating outputs
  output logic wakeOut_n,
  output logic memAccessEn,
  output logic interruptEn,
  output logic pciDriveEn,
  output logic d0Active,
  output logic loadBusy,
  output logic loadTimeout,
  // identity fields
  output logic [15:0] vendorId,
  output logic [15:0] deviceId,
  output logic [23:0] classCode,
  output logic [15:0] subVendorId,
  output logic [15:0] subsystemId,
  // eeprom pins; select is two-way, sampled after reset
  input wire logic eeprom_select_pin_in,
  output logic eeprom_select_pin_out,
  output logic eeprom_select_pin_oe_n,
  output logic eeClock,
  output logic eeDataIn,
  input wire logic eeDataOut
);
  typedef enum logic [2:0] {
    LD_STRAP = 3'b000,
    LD_START = 3'b001,
    LD_WAIT = 3'b010,
    LD_DONE = 3'b011
  } ppm_load_t;
  typedef enum logic [1:0] {
    PW_D0_UNINIT = 2'b00,
    PW_D0_ACTIVE = 2'b01,
    PW_D3HOT = 2'b10,
    PW_WAKEUP = 2'b11
  } ppm_power_t;
  localparam logic [16:0] LIMIT_LAST = 17'(LOAD_LIMIT - 1);

  ppm_load_t loadQ;
  ppm_power_t powerQ;
  logic [16:0] loadCntQ;
  logic [2:0] wordIdxQ;
  logic wakeEnQ, wakeStatQ;
  logic [1:0] pStateQ;
  logic [31:0] userQ;
  logic [CHANNELS-1:0] rxPrevQ;
  logic [CHANNELS*4-1:0] deltaPrevQ;
  logic rdStart, rdBusy, rdDone, rdSel;
  logic [15:0] rdWord;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  // event detect: falling receive line or rising delta flag
  wire [CHANNELS-1:0] startEdge = rxPrevQ & ~rxLine;
  wire [CHANNELS*4-1:0] deltaRise = modemDelta & ~deltaPrevQ;
  wire inD3 = (powerQ == PW_D3HOT);
  wire wakeEvent = inD3 && ((|startEdge) || (|deltaRise));
  wire csrWr = cfgWrite && hit(cfgAddr, ppm_pkg::OFS_CSR);
  wire stateWr = csrWr && cfgByteEn[0];
  wire enWr = csrWr && cfgByteEn[1];
  wire clrStat = enWr && cfgWdata[ppm_pkg::CSR_WAKE_STATUS_BIT];
  // unsupported encodings leave the state alone
  wire stateOk = (cfgWdata[1:0] == ppm_pkg::PS_D0) || (cfgWdata[1:0] == ppm_pkg::PS_D3HOT);
  wire toD3 = stateWr && stateOk && (cfgWdata[1:0] == ppm_pkg::PS_D3HOT);
  wire toD0 = stateWr && stateOk && (cfgWdata[1:0] == ppm_pkg::PS_D0);

  wire [31:0] capWord = {ppm_pkg::CAP_WAKE_SUPPORT, 7'h00, ppm_pkg::CAP_CLOCK,
                         ppm_pkg::CAP_VERSION, ppm_pkg::CAP_NEXT, ppm_pkg::CAP_ID};
  wire [31:0] csrWord = {16'h0000, wakeStatQ, 6'h00, wakeEnQ, 6'h00, pStateQ};
  wire [31:0] rdMux =
    hit(cfgAddr, ppm_pkg::OFS_CAP) ? capWord :
    hit(cfgAddr, ppm_pkg::OFS_CSR) ? csrWord :
    hit(cfgAddr, ppm_pkg::OFS_USER) ? userQ :
    hit(cfgAddr, ppm_pkg::OFS_VENDOR) ? {deviceId, vendorId} :
    hit(cfgAddr, ppm_pkg::OFS_CLASS) ? {classCode, ppm_pkg::DEF_REVISION} :
    hit(cfgAddr, ppm_pkg::OFS_SUBSYS) ? {subsystemId, subVendorId} : 32'h00000000;

  // strap caught by clocked logic after reset release
  assign rdStart = (loadQ == LD_START);
  wire timeUp = (loadCntQ == LIMIT_LAST);

  ppm_eeprom_reader #(
    .ADDR_BITS(ppm_pkg::EE_ADDR_BITS),
    .CLK_DIV(ppm_pkg::EE_CLK_DIV)
  ) u_reader (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(rdStart),
    .wordAddr({3'h0, wordIdxQ}),
    .busy(rdBusy),
    .done(rdDone),
    .wordData(rdWord),
    .eeSelect(rdSel),
    .eeClock(eeClock),
    .eeDataIn(eeDataIn),
    .eeDataOut(eeDataOut)
  );

  // loader sequence
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loadQ <= LD_STRAP;
      loadCntQ <= 17'h00000;
      wordIdxQ <= 3'h0;
      loadTimeout <= 1'b0;
      loadBusy <= 1'b1;
    end else begin
      if (loadQ != LD_DONE) begin
        loadCntQ <= loadCntQ + 17'h00001;
      end
      case (loadQ)
        LD_STRAP: begin
          loadQ <= eeprom_select_pin_in ? LD_START : LD_DONE;
          loadBusy <= eeprom_select_pin_in;
        end
        LD_START: begin
          // limit can fall here too, between two words
          if (timeUp) begin
            loadQ <= LD_DONE;
            loadTimeout <= 1'b1;
            loadBusy <= 1'b0;
          end else begin
            loadQ <= LD_WAIT;
          end
        end
        LD_WAIT: begin
          if (timeUp) begin
            loadQ <= LD_DONE;
            loadTimeout <= 1'b1;
            loadBusy <= 1'b0;
          end else if (rdDone) begin
            wordIdxQ <= wordIdxQ + 3'h1;
            if (wordIdxQ == 3'(ppm_pkg::EE_WORDS - 1)) begin
              loadQ <= LD_DONE;
              loadBusy <= 1'b0;
            end else begin
              loadQ <= LD_START;
            end
          end
        end
        default: begin
          loadQ <= LD_DONE;
          loadBusy <= 1'b0;
        end
      endcase
    end
  end

  // identity field update from loaded words
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vendorId <= ppm_pkg::DEF_VENDOR;
      deviceId <= ppm_pkg::DEF_DEVICE;
      classCode <= ppm_pkg::DEF_CLASS;
      subVendorId <= 16'h0000;
      subsystemId <= 16'h0000;
      userQ <= ppm_pkg::USER_RESET;
    end else if (loadQ == LD_WAIT && rdDone && !timeUp) begin
      case (wordIdxQ)
        3'h0: vendorId <= rdWord;
        3'h1: deviceId <= rdWord;
        3'h2: classCode[7:0] <= rdWord[15:8];
        3'h3: classCode[23:8] <= rdWord;
        3'h4: subVendorId <= rdWord;
        3'h5: subsystemId <= rdWord;
        3'h6: userQ[15:0] <= rdWord;
        default: userQ[31:16] <= rdWord;
      endcase
    end
  end

  // power state and control/status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powerQ <= PW_D0_UNINIT;
      pStateQ <= ppm_pkg::PS_D0;
      wakeEnQ <= 1'b0;
      wakeStatQ <= 1'b0;
      rxPrevQ <= '1;
      deltaPrevQ <= '0;
    end else begin
      rxPrevQ <= rxLine;
      deltaPrevQ <= modemDelta;
      if (enWr) begin
        wakeEnQ <= cfgWdata[ppm_pkg::CSR_WAKE_EN_BIT];
      end
      // set wins over the write-one clear
      wakeStatQ <= wakeEvent | (wakeStatQ & ~clrStat);
      if (toD3 || toD0) begin
        pStateQ <= cfgWdata[1:0];
      end
      case (powerQ)
        PW_D0_UNINIT: begin
          if (swInitDone) powerQ <= PW_D0_ACTIVE;
          if (toD3) powerQ <= PW_D3HOT;
        end
        PW_D0_ACTIVE: begin
          if (toD3) powerQ <= PW_D3HOT;
        end
        PW_D3HOT: begin
          if (toD0) powerQ <= PW_WAKEUP;
        end
        default: begin
          powerQ <= PW_D0_ACTIVE;
        end
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfgRdata <= 32'h00000000;
      cfgRvalid <= 1'b0;
      wakeOut_n <= 1'b1;
      memAccessEn <= 1'b0;
      interruptEn <= 1'b0;
      pciDriveEn <= 1'b1;
      d0Active <= 1'b0;
      eeprom_select_pin_out <= 1'b0;
      eeprom_select_pin_oe_n <= 1'b1;
    end else begin
      cfgRvalid <= cfgRead;
      cfgRdata <= cfgRead ? rdMux : 32'h00000000;
      wakeOut_n <= ~(inD3 && wakeEnQ && (wakeStatQ || wakeEvent));
      memAccessEn <= (powerQ == PW_D0_ACTIVE) && !toD3;
      interruptEn <= (powerQ == PW_D0_ACTIVE) && !toD3;
      pciDriveEn <= !((powerQ == PW_D3HOT && toD0) || powerQ == PW_WAKEUP);
      d0Active <= (powerQ == PW_D0_ACTIVE);
      eeprom_select_pin_out <= rdSel;
      eeprom_select_pin_oe_n <= !(rdBusy || rdStart);
    end
  end

  // channel receive path is outside this block and is never gated here

  // assertions
  sequence d3Entered;
    powerQ == PW_D3HOT;
  endsequence

  sequence wakeupSteps;
    !pciDriveEn ##1 powerQ == PW_D0_ACTIVE;
  endsequence

  capWordFixed_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfgRead && hit(cfgAddr, ppm_pkg::OFS_CAP) |=> cfgRdata == 32'h400A0001)
    else $error("capability word wrong");
  csrUpperZero_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfgRvalid && $past(hit(cfgAddr, ppm_pkg::OFS_CSR)) |-> cfgRdata[31:16] == 16'h0000 &&
    cfgRdata[14:9] == 6'h00 && cfgRdata[7:2] == 6'h00)
    else $error("csr reserved bits set");
  wakeStatSet_a: assert property (@(posedge clk_sys) disable iff (rst)
    wakeEvent |=> wakeStatQ)
    else $error("wake status not set");
  wakeStatHold_a: assert property (@(posedge clk_sys) disable iff (rst)
    wakeStatQ && !clrStat |=> wakeStatQ)
    else $error("wake status lost");
  wakeOnlyD3_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wakeOut_n |-> $past(inD3) && $past(wakeEnQ))
    else $error("wake asserted outside D3hot");
  wakeHeld_a: assert property (@(posedge clk_sys) disable iff (rst)
    inD3 && wakeEnQ && wakeStatQ |=> !wakeOut_n)
    else $error("wake not held while status set");
  badStateIgnored_a: assert property (@(posedge clk_sys) disable iff (rst)
    stateWr && !stateOk |=> $stable(pStateQ))
    else $error("unsupported state accepted");
  d3MemOff_a: assert property (@(posedge clk_sys) disable iff (rst)
    d3Entered ##1 d3Entered |-> !memAccessEn && !interruptEn)
    else $error("memory access in D3hot");
  toD3Gates_a: assert property (@(posedge clk_sys) disable iff (rst)
    toD3 |=> !memAccessEn && !interruptEn)
    else $error("memory access after D3hot entry");
  rvalidAnswer_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfgRead |=> cfgRvalid)
    else $error("config read not answered");
  d0UninitOff_a: assert property (@(posedge clk_sys) disable iff (rst)
    powerQ == PW_D0_UNINIT |=> !d0Active && !memAccessEn)
    else $error("uninitialized state treated as active");
  drvOffWake_a: assert property (@(posedge clk_sys) disable iff (rst)
    d3Entered ##0 toD0 |=> wakeupSteps)
    else $error("drivers on during wakeup");
  userReadOnly_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(loadQ == LD_WAIT && rdDone) |=> $stable(userQ))
    else $error("user word changed outside load");
  strapGatesLoad_a: assert property (@(posedge clk_sys) disable iff (rst)
    loadQ == LD_STRAP && !eeprom_select_pin_in |=> loadQ == LD_DONE)
    else $error("load started without strap");
  selDriven_a: assert property (@(posedge clk_sys) disable iff (rst)
    rdBusy |=> !eeprom_select_pin_oe_n)
    else $error("select pin not driven during frame");
  loadBound_a: assert property (@(posedge clk_sys) disable iff (rst)
    loadQ != LD_DONE |-> loadCntQ <= LIMIT_LAST)
    else $error("load exceeded limit");
  timeoutSticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    loadTimeout |=> loadTimeout)
    else $error("timeout flag lost");
endmodule
`default_nettype wire

// File: ppm_eeprom_model.sv
// behavioural serial eeprom answering three-wire read frames
`timescale 1ns/1ps
`default_nettype none
module ppm_eeprom_model (
  // eeprom pins
  input wire logic eeSelect,
  input wire logic eeClock,
  input wire logic eeDataIn,
  output logic eeDataOut,
  // stored words, word i at bits 16*i
  input wire logic [127:0] memWords
);
  int bitCount;
  logic [8:0] cmd;
  logic [15:0] word;
  initial begin
    bitCount = 0;
    eeDataOut = 1'b0;
  end
  // leading zeros before the start bit are skipped
  always @(posedge eeClock) begin
    if (eeSelect && (bitCount > 0 || eeDataIn)) begin
      if (bitCount < 9) begin
        cmd = {cmd[7:0], eeDataIn};
      end
      bitCount++;
      if (bitCount == 9) begin
        word = (cmd[8:6] == 3'b110 && cmd[5:3] == 3'b000) ? memWords[16*cmd[2:0]+:16] : 16'h0;
      end
    end
  end
  // data bits msb first, one per serial clock
  always @(negedge eeClock) begin
    if (eeSelect && bitCount >= 9 && bitCount < 25) begin
      eeDataOut = word[24-bitCount];
    end
  end
  // released line inverts the last bit it showed
  always @(negedge eeSelect) begin
    bitCount = 0;
    eeDataOut = ~eeDataOut;
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for power management and eeprom load
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, rst, cfgWrite, cfgRead, swInitDone, strap, eeDataOut, cfgRvalid, wakeOut_n;
  logic memAccessEn, interruptEn, pciDriveEn, d0Active, loadBusy, loadTimeout;
  logic selOut, selOe_n, eeClock, eeDataIn;
  logic [7:0] cfgAddr;
  logic [31:0] cfgWdata, cfgRdata, rnd;
  logic [3:0] cfgByteEn, rxLine;
  logic [15:0] modemDelta, vendorId, deviceId, subVendorId, subsystemId;
  logic [23:0] classCode;
  logic [127:0] memWords;
  wire selWire = selOe_n ? strap : selOut;
  int bad_count, tests_run, psExp, enExp, stExp, lowCnt, n;
  ppm_power_mgmt #(.LOAD_LIMIT(2048)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
    .cfgByteEn(cfgByteEn), .cfgRdata(cfgRdata), .cfgRvalid(cfgRvalid),
    .swInitDone(swInitDone), .rxLine(rxLine), .modemDelta(modemDelta),
    .wakeOut_n(wakeOut_n), .memAccessEn(memAccessEn), .interruptEn(interruptEn),
    .pciDriveEn(pciDriveEn), .d0Active(d0Active), .loadBusy(loadBusy),
    .loadTimeout(loadTimeout), .vendorId(vendorId), .deviceId(deviceId),
    .classCode(classCode), .subVendorId(subVendorId), .subsystemId(subsystemId),
    .eeprom_select_pin_in(selWire), .eeprom_select_pin_out(selOut),
    .eeprom_select_pin_oe_n(selOe_n), .eeClock(eeClock), .eeDataIn(eeDataIn),
    .eeDataOut(eeDataOut));
  ppm_eeprom_model i_mem (.eeSelect(selWire), .eeClock(eeClock), .eeDataIn(eeDataIn),
    .eeDataOut(eeDataOut), .memWords(memWords));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (pciDriveEn !== 1'b1) lowCnt++;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [31:0] csr();
    return 32'((stExp << 15) | (enExp << 8) | psExp);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgWdata = d;
    cfgByteEn = be;
    cfgWrite = 1'b1;
    @(negedge clk_sys);
    cfgWrite = 1'b0;
  endtask
  // answer stands one cycle after the request edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge clk_sys);
    cfgRead = 1'b0;
    chk(cfgRvalid === 1'b1 ? cfgRdata : ~exp, exp);
  endtask
  task automatic do_reset(input logic s);
    @(negedge clk_sys);
    strap = s;
    rst = 1'b1;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    psExp = 0;
    enExp = 0;
    stExp = 0;
  endtask
  // source 0..3 receive line falls, 4..19 modem delta rises
  task automatic wake(input int i, input int en);
    enExp = en;
    wr(8'h44, csr(), 4'h3);
    if (i < 4) rxLine[i] = 1'b0;
    else modemDelta[i-4] = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(32'(wakeOut_n), 32'(en == 0));
    rxLine = 4'hF;
    modemDelta = 16'h0;
    stExp = 1;
    rd(8'h44, csr());
    wr(8'h44, csr(), 4'h2);
    stExp = 0;
    rd(8'h44, csr());
    chk(32'(wakeOut_n), 32'h1);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    cfgWrite = 1'b0;
    cfgRead = 1'b0;
    cfgAddr = 8'h00;
    cfgWdata = 32'h0;
    cfgByteEn = 4'h0;
    swInitDone = 1'b0;
    rxLine = 4'hF;
    modemDelta = 16'h0;
    strap = 1'b0;
    rnd = 32'hD75C;
    for (int k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      memWords[16*k+:16] = rnd[15:0];
    end
    do_reset(1'b0);
    rd(8'h40, 32'h400A0001);
    rd(8'h44, 32'h0);
    rd(8'h48, ppm_pkg::USER_RESET);
    rd(8'h00, {ppm_pkg::DEF_DEVICE, ppm_pkg::DEF_VENDOR});
    rd(8'h08, {ppm_pkg::DEF_CLASS, ppm_pkg::DEF_REVISION});
    rd(8'h4C, 32'h0);
    chk(32'({d0Active, memAccessEn, interruptEn}), 32'h0);
    @(negedge clk_sys);
    swInitDone = 1'b1;
    @(negedge clk_sys);
    swInitDone = 1'b0;
    @(negedge clk_sys);
    chk(32'({d0Active, memAccessEn, interruptEn}), 32'h7);
    wr(8'h40, 32'hFFFFFFFF, 4'hF);
    wr(8'h48, 32'hFFFFFFFF, 4'hF);
    rd(8'h40, 32'h400A0001);
    rd(8'h48, 32'h0);
    for (int v = 1; v < 3; v++) begin
      wr(8'h44, 32'(v), 4'h1);
      rd(8'h44, csr());
    end
    rxLine[2] = 1'b0;
    repeat (3) @(negedge clk_sys);
    rxLine = 4'hF;
    chk(32'(wakeOut_n), 32'h1);
    rd(8'h44, csr());
    wr(8'h44, 32'hFFFFFFFF, 4'hF);
    psExp = 3;
    enExp = 1;
    rd(8'h44, csr());
    repeat (2) @(negedge clk_sys);
    chk(32'({d0Active, memAccessEn, interruptEn}), 32'h0);
    for (int i = 0; i < 20; i++) begin
      wake(i, (i % 5) != 0);
    end
    lowCnt = 0;
    psExp = 0;
    wr(8'h44, csr(), 4'h1);
    repeat (6) @(negedge clk_sys);
    chk(32'(lowCnt), 32'h2);
    chk(32'({d0Active, memAccessEn, interruptEn}), 32'h7);
    rd(8'h44, csr());
    psExp = 3;
    wr(8'h44, csr(), 4'h1);
    do_reset(1'b1);
    n = 0;
    while (loadBusy !== 1'b0 && n < 2100) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'({loadBusy, loadTimeout}), 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h00, memWords[31:0]);
    rd(8'h08, {memWords[63:48], memWords[47:40], ppm_pkg::DEF_REVISION});
    rd(8'h2C, memWords[95:64]);
    rd(8'h48, memWords[127:96]);
    chk({vendorId, deviceId}, {memWords[15:0], memWords[31:16]});
    chk({subVendorId, subsystemId}, {memWords[79:64], memWords[95:80]});
    chk(32'(classCode), 32'({memWords[63:48], memWords[47:40]}));
    wrap_up();
  end
endmodule
`default_nettype wire
